// >>> hdl/csfr_pkg.sv
// Package with addresses, reset values and carrier types of the core bank.
package csfr_pkg;

    // Special-function locations, 12-bit data-memory addresses.
    localparam logic [11:0] A_STACK_TOP_UPPER  = 12'hFFF;
    localparam logic [11:0] A_STACK_TOP_HIGH   = 12'hFFE;
    localparam logic [11:0] A_STACK_TOP_LOW    = 12'hFFD;
    localparam logic [11:0] A_STACK_POINTER    = 12'hFFC;
    localparam logic [11:0] A_PC_UPPER_HOLD    = 12'hFFB;
    localparam logic [11:0] A_PC_HIGH_HOLD     = 12'hFFA;
    localparam logic [11:0] A_PC_LOW           = 12'hFF9;
    localparam logic [11:0] A_TABLE_PTR_UPPER  = 12'hFF8;
    localparam logic [11:0] A_TABLE_PTR_HIGH   = 12'hFF7;
    localparam logic [11:0] A_TABLE_PTR_LOW    = 12'hFF6;
    localparam logic [11:0] A_TABLE_LATCH      = 12'hFF5;
    localparam logic [11:0] A_PRODUCT_HIGH     = 12'hFF4;
    localparam logic [11:0] A_PRODUCT_LOW      = 12'hFF3;
    localparam logic [11:0] A_INT_CTRL_MAIN    = 12'hFF2;
    localparam logic [11:0] A_INT_CTRL_EDGE    = 12'hFF1;
    localparam logic [11:0] A_INT_CTRL_EXT     = 12'hFF0;
    localparam logic [11:0] A_IND0_PLAIN       = 12'hFEF;
    localparam logic [11:0] A_IND0_POSTINC     = 12'hFEE;
    localparam logic [11:0] A_IND0_POSTDEC     = 12'hFED;
    localparam logic [11:0] A_IND0_PREINC      = 12'hFEC;
    localparam logic [11:0] A_IND0_OFFSET      = 12'hFEB;
    localparam logic [11:0] A_POINTER0_HIGH    = 12'hFEA;
    localparam logic [11:0] A_POINTER0_LOW     = 12'hFE9;
    localparam logic [11:0] A_WORKING          = 12'hFE8;
    localparam logic [11:0] A_IND1_PLAIN       = 12'hFE7;
    localparam logic [11:0] A_IND1_POSTINC     = 12'hFE6;
    localparam logic [11:0] A_IND1_POSTDEC     = 12'hFE5;

    // Field positions.
    localparam int STK_FULL_BIT     = 7;
    localparam int STK_UNDERFLOW_BIT = 6;
    localparam int TBL_CONFIG_BIT   = 21;

    // Values after power-on and brown-out reset.
    localparam logic [7:0] RST_ZERO          = 8'h00;
    localparam logic [7:0] RST_INT_CTRL_EDGE = 8'hFF;
    localparam logic [7:0] RST_INT_CTRL_EXT  = 8'hC0;

    typedef enum logic [2:0] {
        CSFR_OP_PLAIN,
        CSFR_OP_POSTINC,
        CSFR_OP_POSTDEC,
        CSFR_OP_PREINC,
        CSFR_OP_OFFSET
    } csfr_op_t;

    typedef enum {
        CSFR_ST_IDLE,
        CSFR_ST_MEM,
        CSFR_ST_WAIT
    } csfr_state_t;

    // One access from the core.
    typedef struct packed {
        logic        write;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } csfr_req_t;

    // One access to data memory made on behalf of an indirect port.
    typedef struct packed {
        logic        req;
        logic        write;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } csfr_mem_t;

    // Register contents the core logic uses.
    typedef struct packed {
        logic [20:0] stack_top;
        logic [4:0]  stack_ptr;
        logic        stack_full;
        logic        stack_underflow;
        logic [4:0]  pc_upper;
        logic [7:0]  pc_high;
        logic [7:0]  pc_low;
        logic [21:0] table_ptr;
        logic        table_to_config;
        logic [7:0]  table_latch;
        logic [15:0] product;
        logic [7:0]  int_main;
        logic [7:0]  int_edge;
        logic [7:0]  int_ext;
        logic [7:0]  working;
    } csfr_view_t;

endpackage

// >>> hdl/csfr_pointer.sv
// One indirect-addressing pointer with its address modes.
`timescale 1ns/1ps
module csfr_pointer
    import csfr_pkg::*;
(
    // Clock and reset.
    input  wire logic        clock,
    input  wire logic        rst,
    // Direct writes of the pointer bytes.
    input  wire logic        wr_high,
    input  wire logic        wr_low,
    input  wire logic [7:0]  wdata,
    // Indirect access control.
    input  wire csfr_op_t    op,
    input  wire logic        start,
    input  wire logic        finish,
    input  wire logic [7:0]  working,
    // Pointer value and the address for the current mode.
    output logic      [11:0] ptr,
    output logic      [11:0] eff_addr
);

    logic [11:0] ptr_reg;
    logic [11:0] offset;

    assign ptr = ptr_reg;
    // Working register is treated as signed.
    assign offset = {{4{working[7]}}, working};

    always_comb begin
        case (op)
            CSFR_OP_PREINC: eff_addr = ptr_reg + 12'h001;
            CSFR_OP_OFFSET: eff_addr = ptr_reg + offset;
            default:        eff_addr = ptr_reg;
        endcase
    end

    // Pre-increment is applied when the access starts, the post modes
    // once the memory access has completed.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ptr_reg <= 12'h000;
        end else if (start && op == CSFR_OP_PREINC) begin
            ptr_reg <= ptr_reg + 12'h001;
        end else if (finish && op == CSFR_OP_POSTINC) begin
            ptr_reg <= ptr_reg + 12'h001;
        end else if (finish && op == CSFR_OP_POSTDEC) begin
            ptr_reg <= ptr_reg - 12'h001;
        end else if (wr_high) begin
            ptr_reg[11:8] <= wdata[3:0];
        end else if (wr_low) begin
            ptr_reg[7:0] <= wdata;
        end
    end

endmodule

// >>> hdl/csfr_bank.sv
// Core special-function register bank with indirect-access ports.
`timescale 1ns/1ps
// Functional notes
// - Indirect port reaches memory byte at pointer
// - Plain port uses pointer, leaves it unchanged
// - Post-increment port adds one after access
// - Post-decrement port subtracts one after access
// - Table pointer low byte holds bits 7:0
// - Table latch clears to zero at reset
// - Stack full/underflow stay set until cleared
// - Table pointer bit 21 selects configuration space
// - Unused locations read as zero
module csfr_bank
    import csfr_pkg::*;
(
    // Clock and reset.
    input  wire logic        clock,
    input  wire logic        rst,
    // Core access port.
    input  wire logic        req_valid,
    input  wire csfr_req_t   req,
    output logic             req_ready,
    output logic             rsp_valid,
    output logic [7:0]       rsp_rdata,
    // Data-memory access port.
    output csfr_mem_t        mem,
    input  wire logic [7:0]  mem_rdata,
    // Core hardware updates.
    input  wire logic        stack_full_set,
    input  wire logic        stack_underflow_set,
    input  wire logic        table_latch_load,
    input  wire logic [7:0]  table_latch_data,
    input  wire logic        product_load,
    input  wire logic [15:0] product_data,
    input  wire logic [5:0]  int_flag_set,
    // Register view.
    output csfr_view_t       view
);

    csfr_state_t state_reg;
    csfr_op_t    op_reg;
    csfr_op_t    op_now;
    logic        ptr_sel_reg;
    logic        ptr_sel_now;
    logic        is_ind;
    logic        take;
    logic        loc_wr;
    logic        finish;
    logic [7:0]  rd_mux;
    logic [11:0] ptr0;
    logic [11:0] ptr1;
    logic [11:0] eff0;
    logic [11:0] eff1;
    csfr_op_t    op0;
    csfr_op_t    op1;

    assign take   = req_valid && req_ready;
    assign loc_wr = take && req.write && !is_ind;
    assign finish = (state_reg == CSFR_ST_WAIT);

    // Decode of the indirect ports; they hold no storage of their own.
    always_comb begin
        is_ind      = 1'b1;
        ptr_sel_now = 1'b0;
        op_now      = CSFR_OP_PLAIN;
        case (req.addr)
            A_IND0_PLAIN:   op_now = CSFR_OP_PLAIN;
            A_IND0_POSTINC: op_now = CSFR_OP_POSTINC;
            A_IND0_POSTDEC: op_now = CSFR_OP_POSTDEC;
            A_IND0_PREINC:  op_now = CSFR_OP_PREINC;
            A_IND0_OFFSET:  op_now = CSFR_OP_OFFSET;
            A_IND1_PLAIN: begin
                ptr_sel_now = 1'b1;
            end
            A_IND1_POSTINC: begin
                ptr_sel_now = 1'b1;
                op_now      = CSFR_OP_POSTINC;
            end
            A_IND1_POSTDEC: begin
                ptr_sel_now = 1'b1;
                op_now      = CSFR_OP_POSTDEC;
            end
            default: is_ind = 1'b0;
        endcase
    end

    // The unit that is not in use sees the plain mode, so it stays still.
    assign op0 = (state_reg == CSFR_ST_IDLE)
                 ? (ptr_sel_now ? CSFR_OP_PLAIN : op_now)
                 : (ptr_sel_reg ? CSFR_OP_PLAIN : op_reg);
    assign op1 = (state_reg == CSFR_ST_IDLE)
                 ? (ptr_sel_now ? op_now : CSFR_OP_PLAIN)
                 : (ptr_sel_reg ? op_reg : CSFR_OP_PLAIN);

    csfr_pointer u_pointer0 (
        .clock    (clock),
        .rst      (rst),
        .wr_high  (loc_wr && req.addr == A_POINTER0_HIGH),
        .wr_low   (loc_wr && req.addr == A_POINTER0_LOW),
        .wdata    (req.wdata),
        .op       (op0),
        .start    (take && is_ind && !ptr_sel_now),
        .finish   (finish && !ptr_sel_reg),
        .working  (view.working),
        .ptr      (ptr0),
        .eff_addr (eff0)
    );

    // Pointer one has no byte registers in this bank; it is moved only by
    // its own post-modify ports.
    csfr_pointer u_pointer1 (
        .clock    (clock),
        .rst      (rst),
        .wr_high  (1'b0),
        .wr_low   (1'b0),
        .wdata    (req.wdata),
        .op       (op1),
        .start    (take && is_ind && ptr_sel_now),
        .finish   (finish && ptr_sel_reg),
        .working  (view.working),
        .ptr      (ptr1),
        .eff_addr (eff1)
    );

    // Access sequencer: indirect accesses spend three cycles.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg   <= CSFR_ST_IDLE;
            op_reg      <= CSFR_OP_PLAIN;
            ptr_sel_reg <= 1'b0;
            req_ready   <= 1'b1;
            mem         <= '0;
        end else begin
            case (state_reg)
                CSFR_ST_IDLE: begin
                    if (take && is_ind) begin
                        state_reg   <= CSFR_ST_MEM;
                        op_reg      <= op_now;
                        ptr_sel_reg <= ptr_sel_now;
                        req_ready   <= 1'b0;
                        mem.req     <= 1'b1;
                        mem.write   <= req.write;
                        mem.wdata   <= req.wdata;
                        mem.addr    <= ptr_sel_now ? eff1 : eff0;
                    end
                end
                CSFR_ST_MEM: begin
                    mem.req   <= 1'b0;
                    state_reg <= CSFR_ST_WAIT;
                end
                CSFR_ST_WAIT: begin
                    req_ready <= 1'b1;
                    state_reg <= CSFR_ST_IDLE;
                end
                default: begin
                    req_ready <= 1'b1;
                    mem.req   <= 1'b0;
                    state_reg <= CSFR_ST_IDLE;
                end
            endcase
        end
    end

    // Read mux for the storage-backed locations.
    always_comb begin
        case (req.addr)
            A_STACK_TOP_UPPER: rd_mux = {3'h0, view.stack_top[20:16]};
            A_STACK_TOP_HIGH:  rd_mux = view.stack_top[15:8];
            A_STACK_TOP_LOW:   rd_mux = view.stack_top[7:0];
            A_STACK_POINTER:   rd_mux = {view.stack_full,
                                         view.stack_underflow, 1'b0,
                                         view.stack_ptr};
            A_PC_UPPER_HOLD:   rd_mux = {3'h0, view.pc_upper};
            A_PC_HIGH_HOLD:    rd_mux = view.pc_high;
            A_PC_LOW:          rd_mux = view.pc_low;
            A_TABLE_PTR_UPPER: rd_mux = {2'h0, view.table_ptr[21:16]};
            A_TABLE_PTR_HIGH:  rd_mux = view.table_ptr[15:8];
            A_TABLE_PTR_LOW:   rd_mux = view.table_ptr[7:0];
            A_TABLE_LATCH:     rd_mux = view.table_latch;
            A_PRODUCT_HIGH:    rd_mux = view.product[15:8];
            A_PRODUCT_LOW:     rd_mux = view.product[7:0];
            A_INT_CTRL_MAIN:   rd_mux = view.int_main;
            A_INT_CTRL_EDGE:   rd_mux = view.int_edge;
            A_INT_CTRL_EXT:    rd_mux = view.int_ext;
            A_POINTER0_HIGH:   rd_mux = {4'h0, ptr0[11:8]};
            A_POINTER0_LOW:    rd_mux = ptr0[7:0];
            A_WORKING:         rd_mux = view.working;
            default:           rd_mux = 8'h00;
        endcase
    end

    // Answer to the core: next cycle for plain locations, after the
    // memory round trip for indirect ports; writes answer zero.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= RST_ZERO;
        end else if (finish) begin
            rsp_valid <= 1'b1;
            rsp_rdata <= mem.write ? RST_ZERO : mem_rdata;
        end else if (take && !is_ind) begin
            rsp_valid <= 1'b1;
            rsp_rdata <= req.write ? RST_ZERO : rd_mux;
        end else begin
            rsp_valid <= 1'b0;
        end
    end

    // Return-stack window and pointer.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            view.stack_top <= 21'h000000;
            view.stack_ptr <= 5'h00;
        end else if (loc_wr) begin
            case (req.addr)
                A_STACK_TOP_UPPER: view.stack_top[20:16] <= req.wdata[4:0];
                A_STACK_TOP_HIGH:  view.stack_top[15:8] <= req.wdata;
                A_STACK_TOP_LOW:   view.stack_top[7:0] <= req.wdata;
                A_STACK_POINTER:   view.stack_ptr <= req.wdata[4:0];
                default:           view.stack_top <= view.stack_top;
            endcase
        end
    end

    // Sticky stack flags: software may only clear them, and a hardware
    // set in the same cycle wins over that clear.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            view.stack_full      <= 1'b0;
            view.stack_underflow <= 1'b0;
        end else begin
            if (stack_full_set) begin
                view.stack_full <= 1'b1;
            end else if (loc_wr && req.addr == A_STACK_POINTER
                         && !req.wdata[STK_FULL_BIT]) begin
                view.stack_full <= 1'b0;
            end
            if (stack_underflow_set) begin
                view.stack_underflow <= 1'b1;
            end else if (loc_wr && req.addr == A_STACK_POINTER
                         && !req.wdata[STK_UNDERFLOW_BIT]) begin
                view.stack_underflow <= 1'b0;
            end
        end
    end

    // Program-counter latches.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            view.pc_upper <= 5'h00;
            view.pc_high  <= RST_ZERO;
            view.pc_low   <= RST_ZERO;
        end else if (loc_wr) begin
            case (req.addr)
                A_PC_UPPER_HOLD: view.pc_upper <= req.wdata[4:0];
                A_PC_HIGH_HOLD:  view.pc_high <= req.wdata;
                A_PC_LOW:        view.pc_low <= req.wdata;
                default:         view.pc_low <= view.pc_low;
            endcase
        end
    end

    // Table pointer and latch.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            view.table_ptr       <= 22'h000000;
            view.table_to_config <= 1'b0;
        end else if (loc_wr) begin
            case (req.addr)
                A_TABLE_PTR_UPPER: begin
                    view.table_ptr[21:16] <= req.wdata[5:0];
                    view.table_to_config <= req.wdata[TBL_CONFIG_BIT - 16];
                end
                A_TABLE_PTR_HIGH: view.table_ptr[15:8] <= req.wdata;
                A_TABLE_PTR_LOW:  view.table_ptr[7:0] <= req.wdata;
                default:          view.table_ptr <= view.table_ptr;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            view.table_latch <= RST_ZERO;
        end else if (table_latch_load) begin
            view.table_latch <= table_latch_data;
        end else if (loc_wr && req.addr == A_TABLE_LATCH) begin
            view.table_latch <= req.wdata;
        end
    end

    // Product bytes and working register.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            view.product <= 16'h0000;
            view.working <= RST_ZERO;
        end else begin
            if (product_load) begin
                view.product <= product_data;
            end else if (loc_wr && req.addr == A_PRODUCT_HIGH) begin
                view.product[15:8] <= req.wdata;
            end else if (loc_wr && req.addr == A_PRODUCT_LOW) begin
                view.product[7:0] <= req.wdata;
            end
            if (loc_wr && req.addr == A_WORKING) begin
                view.working <= req.wdata;
            end
        end
    end

    // Interrupt control; hardware flag sets win over a software write.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            view.int_main <= RST_ZERO;
            view.int_edge <= RST_INT_CTRL_EDGE;
            view.int_ext  <= RST_INT_CTRL_EXT;
        end else begin
            if (loc_wr && req.addr == A_INT_CTRL_MAIN) begin
                view.int_main <= req.wdata | {5'h00, int_flag_set[2:0]};
            end else begin
                view.int_main[2:0] <= view.int_main[2:0] | int_flag_set[2:0];
            end
            if (loc_wr && req.addr == A_INT_CTRL_EDGE) begin
                view.int_edge <= req.wdata;
            end
            if (loc_wr && req.addr == A_INT_CTRL_EXT) begin
                view.int_ext <= req.wdata | {5'h00, int_flag_set[5:3]};
            end else begin
                view.int_ext[2:0] <= view.int_ext[2:0] | int_flag_set[5:3];
            end
        end
    end

endmodule

// >>> sim/csfr_mem_model.sv
// Data-memory model that answers the bank's indirect accesses.
`timescale 1ns/1ps
module csfr_mem_model
    import csfr_pkg::*;
(
    // Clock.
    input  wire logic      clock,
    // Access from the bank and read data back.
    input  wire csfr_mem_t mem,
    output logic [7:0]     mem_rdata
);
    logic [7:0] ram [4096];

    initial begin
        for (int i = 0; i < 4096; i++) begin
            ram[i] = i[7:0] ^ {2{i[11:8]}};
        end
        mem_rdata = 8'h5A;
    end

    // Read data stands for one cycle only; otherwise the line toggles so a
    // late or early sample cannot match by luck.
    always @(posedge clock) begin
        if (mem.req === 1'b1 && mem.write === 1'b1) begin
            ram[mem.addr] <= mem.wdata;
            mem_rdata <= ~mem_rdata;
        end else if (mem.req === 1'b1) begin
            mem_rdata <= ram[mem.addr];
        end else begin
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule

// >>> sim/csfr_bank_assertions.sv
// Concurrent checks of the core bank's port timing and register behaviour.
`timescale 1ns/1ps
module csfr_bank_assertions
    import csfr_pkg::*;
(
    // Clock and reset.
    input  wire logic        clock,
    input  wire logic        rst,
    // Core side.
    input  wire logic        req_valid,
    input  wire csfr_req_t   req,
    input  wire logic        req_ready,
    input  wire logic        rsp_valid,
    input  wire logic [7:0]  rsp_rdata,
    // Memory and hardware side.
    input  wire csfr_mem_t   mem,
    input  wire logic [7:0]  mem_rdata,
    input  wire logic        stack_full_set,
    input  wire logic        stack_underflow_set,
    input  wire logic        table_latch_load,
    input  wire logic [7:0]  table_latch_data,
    input  wire logic        product_load,
    input  wire logic [15:0] product_data,
    input  wire logic [5:0]  int_flag_set,
    input  wire csfr_view_t  view
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    logic take;
    logic ind;
    assign take = req_valid && req_ready;
    assign ind  = req.addr inside {[12'hFEB:12'hFEF], [12'hFE5:12'hFE7]};

    ind_timing_a: assert property (take && ind |=> mem.req && !req_ready ##1
        !mem.req && !req_ready && !rsp_valid ##1 rsp_valid && req_ready)
        else $error("indirect access timing wrong");
    ind_wdata_a: assert property (take && ind |=> mem.write ==
        $past(req.write) && mem.wdata == $past(req.wdata))
        else $error("indirect access carries wrong data");
    ind_rdata_a: assert property (take && ind && !req.write |->
        ##3 rsp_rdata == $past(mem_rdata))
        else $error("indirect read data not from memory");
    unmapped_read_a: assert property (take && !req.write &&
        req.addr inside {12'hFE4, 12'hFE3} |=> rsp_valid && rsp_rdata == 0)
        else $error("unmapped location read non-zero");
    tbl_low_a: assert property (take && req.write &&
        req.addr == A_TABLE_PTR_LOW |=> view.table_ptr[7:0] == $past(req.wdata))
        else $error("table pointer low byte not written");
    latch_reset_a: assert property ($fell(rst) |->
        view.table_latch == RST_ZERO)
        else $error("table latch not cleared by reset");
    flag_sticky_a: assert property (view.stack_full && !(take &&
        req.write && req.addr == A_STACK_POINTER &&
        !req.wdata[STK_FULL_BIT]) |=> view.stack_full)
        else $error("stack full flag dropped by itself");
    flag_set_a: assert property (stack_underflow_set |=>
        view.stack_underflow)
        else $error("stack underflow flag not set");
    cfg_mirror_a: assert property (view.table_to_config ==
        view.table_ptr[TBL_CONFIG_BIT])
        else $error("configuration select does not follow bit 21");

    cover property (take && ind && req.write);
    cover property (take && ind && !req.write);
    cover property (stack_full_set);
endmodule

bind csfr_bank csfr_bank_assertions u_chk (.clock, .rst, .req_valid, .req,
    .req_ready, .rsp_valid, .rsp_rdata, .mem, .mem_rdata, .stack_full_set,
    .stack_underflow_set, .table_latch_load, .table_latch_data,
    .product_load, .product_data, .int_flag_set, .view);

// >>> sim/tb_top.sv
// Self-checking bench of the core special-function bank.
`timescale 1ns/1ps
module tb_top
    import csfr_pkg::*;
;
    logic        clock = 1'b0;
    logic        rst, req_valid, req_ready, rsp_valid, product_load;
    logic        stack_full_set, stack_underflow_set, table_latch_load;
    csfr_req_t   req;
    csfr_mem_t   mem;
    csfr_view_t  view;
    logic [7:0]  rsp_rdata, mem_rdata, table_latch_data, r, w, d;
    logic [15:0] product_data;
    logic [5:0]  int_flag_set;
    logic [11:0] maddr, p0, p1, a;
    logic [7:0]  sh [4096];
    int          n_fail, tests_run;

    always #50 clock = ~clock;

    csfr_bank DUT (.clock, .rst, .req_valid, .req, .req_ready, .rsp_valid,
        .rsp_rdata, .mem, .mem_rdata, .stack_full_set, .stack_underflow_set,
        .table_latch_load, .table_latch_data, .product_load, .product_data,
        .int_flag_set, .view);
    csfr_mem_model u_mem (.clock, .mem, .mem_rdata);

    always @(posedge clock) if (mem.req === 1'b1) maddr <= mem.addr;

    task automatic chk(logic [11:0] got, logic [11:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Requests stay up until the edge that sees ready, then wait for answer.
    task automatic acc(logic wr, logic [11:0] ad, logic [7:0] dt);
        int i;
        @(negedge clock);
        req_valid = 1'b1;
        req = '{wr, ad, dt};
        for (i = 0; i < 8 && req_ready !== 1'b1; i++) @(negedge clock);
        @(negedge clock);
        req_valid = 1'b0;
        for (i = 0; i < 8 && rsp_valid !== 1'b1; i++) @(negedge clock);
        chk({11'h0, rsp_valid}, 12'h001);
        r = rsp_rdata;
    endtask

    task automatic rd(logic [11:0] ad, logic [7:0] exp);
        acc(1'b0, ad, 8'h00);
        chk({4'h0, r}, {4'h0, exp});
    endtask

    function automatic logic [7:0] rmask(logic [11:0] ad);
        case (ad)
            A_STACK_TOP_UPPER, A_PC_UPPER_HOLD, A_STACK_POINTER: return 8'h1F;
            A_TABLE_PTR_UPPER: return 8'h3F;
            A_POINTER0_HIGH:   return 8'h0F;
            default:           return 8'hFF;
        endcase
    endfunction

    // Ports 0..4 use pointer zero, 5..7 pointer one.
    task automatic ind(int k, logic wr);
        logic [11:0] p;
        logic [11:0] np;
        logic [11:0] ea;
        logic [7:0]  dt;
        p = (k < 5) ? p0 : p1;
        np = p;
        dt = 8'($urandom);
        case (k % 5)
            0: ea = p;
            1: begin ea = p; np = p + 12'h001; end
            2: begin ea = p; np = p - 12'h001; end
            3: begin np = p + 12'h001; ea = np; end
            default: ea = p + {{4{w[7]}}, w};
        endcase
        acc(wr, (k < 5) ? A_IND0_PLAIN - 12'(k) : A_IND1_PLAIN - 12'(k - 5), dt);
        chk(maddr, ea);
        if (wr) sh[ea] = dt;
        chk({4'h0, r}, wr ? 12'h000 : {4'h0, sh[ea]});
        if (k < 5) p0 = np; else p1 = np;
        rd(A_POINTER0_LOW, p0[7:0]);
        rd(A_POINTER0_HIGH, {4'h0, p0[11:8]});
    endtask

    task automatic end_of_test();
        $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        #(100 * 30000);
        n_fail++;
        end_of_test();
    end

    initial begin
        {rst, req_valid, stack_full_set, stack_underflow_set} = 4'hF;
        {req_valid, stack_full_set, stack_underflow_set} = 3'h0;
        {table_latch_load, product_load, int_flag_set} = '0;
        {req, table_latch_data, product_data} = '0;
        {n_fail, tests_run, p0, p1, w} = '0;
        void'($urandom(32'hBFB0));
        for (int i = 0; i < 4096; i++) sh[i] = i[7:0] ^ {2{i[11:8]}};
        repeat (8) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        for (a = 12'hFFF; a >= A_WORKING; a--) begin
            if (a inside {[A_IND0_OFFSET:A_IND0_PLAIN]}) continue;
            rd(a, a == A_INT_CTRL_EDGE ? RST_INT_CTRL_EDGE :
                a == A_INT_CTRL_EXT ? RST_INT_CTRL_EXT : RST_ZERO);
        end
        repeat (30) begin
            a = A_WORKING + 12'($urandom_range(23));
            d = 8'($urandom);
            if (a inside {[A_IND0_OFFSET:A_IND0_PLAIN]}) continue;
            acc(1'b1, a, d);
            rd(a, d & rmask(a));
            if (a == A_POINTER0_LOW) p0[7:0] = d;
            if (a == A_POINTER0_HIGH) p0[11:8] = d[3:0];
            if (a == A_WORKING) w = d;
        end
        foreach (sh[i]) if (i == 12'hFE4 || i == 12'hFE3) begin
            acc(1'b1, 12'(i), 8'hFF);
            rd(12'(i), 8'h00);
        end
        acc(1'b1, A_TABLE_PTR_LOW, 8'hA5);
        rd(A_TABLE_PTR_LOW, 8'hA5);
        acc(1'b1, A_TABLE_PTR_UPPER, 8'h20);
        chk({11'h0, view.table_to_config}, 12'h001);
        acc(1'b1, A_TABLE_PTR_UPPER, 8'h1F);
        chk({11'h0, view.table_to_config}, 12'h000);
        acc(1'b1, A_POINTER0_HIGH, 8'hFF);
        acc(1'b1, A_POINTER0_LOW, 8'hFF);
        p0 = 12'hFFF;
        ind(1, 1'b1);
        ind(2, 1'b0);
        ind(7, 1'b0);
        repeat (40) begin
            if ($urandom_range(3) == 0) begin
                d = 8'($urandom);
                acc(1'b1, A_POINTER0_LOW, d);
                p0[7:0] = d;
                w = 8'($urandom);
                acc(1'b1, A_WORKING, w);
            end
            ind($urandom_range(7), 1'($urandom_range(1)));
        end
        acc(1'b1, A_STACK_POINTER, 8'h00);
        @(negedge clock);
        {stack_full_set, stack_underflow_set, table_latch_load} = 3'h7;
        {product_load, int_flag_set} = 7'h7F;
        table_latch_data = 8'($urandom);
        product_data = 16'($urandom);
        @(negedge clock);
        {stack_full_set, stack_underflow_set, table_latch_load} = 3'h0;
        {product_load, int_flag_set} = 7'h00;
        rd(A_STACK_POINTER, 8'hC0);
        acc(1'b1, A_STACK_POINTER, 8'hC0);
        rd(A_STACK_POINTER, 8'hC0);
        acc(1'b1, A_STACK_POINTER, 8'h40);
        rd(A_STACK_POINTER, 8'h40);
        rd(A_TABLE_LATCH, table_latch_data);
        rd(A_PRODUCT_HIGH, product_data[15:8]);
        rd(A_PRODUCT_LOW, product_data[7:0]);
        chk({9'h0, view.int_main[2:0]}, 12'h007);
        chk({9'h0, view.int_ext[2:0]}, 12'h007);
        // A second reset mid-run must clear the loaded latch and flags.
        @(negedge clock);
        rst = 1'b1;
        repeat (2) @(negedge clock);
        rst = 1'b0;
        rd(A_TABLE_LATCH, RST_ZERO);
        rd(A_STACK_POINTER, RST_ZERO);
        end_of_test();
    end
endmodule
